/* rtl/sps_top.sv */
// start-up, lockout and protection sequencer with pfc stroke timing
//
// Behaviour
// - charge current low below trip, high trip to lockout, low lockout to startup.
// - at startup threshold enable internals, stop charging, start latch source and soft-starts.
// - power-factor stage enabled once latch input enabled and its soft-start charged no later than the flyback one.
// - flyback enabled once its soft-start charged, then it regulates.
// - latch input not enabled by lockout: deactivate and resume charging.
// - flyback control timeout after start flags error and starts safe restart.
// - protection stops both; latched never restarts, safe restart recharges and restarts.
// - output overvoltage suspends power-factor switching while present.
// - mains below stop halts power-factor switching until above higher start level.
// - supply below lockout stops both, drivers off, recharge through startup pin.
// - latch input below 1.25 V is a latched protection.
// - no switching until latch input exceeded 1.35 V; no filtering.
// - mains below 750 mV then up to 870 mV clears latched protection.
// - loss of all power (power-on reset) clears latched protection.
// - overtemperature stops switching and keeps recharge off while active.
// - overtemperature stays latched until power loss or fast mains reset.
// - next stroke only after demagnetization and valley.
// - no demagnetization: zero-current indication 50 us after gate pulse.
// - no valley: synthetic valley 4 us after demagnetization.
// - above maximum frequency run discontinuous, still turning on at a valley.
// - power-factor stage controlled by on-time.
// - soft-start source on below 0.5 V, limited above, off once switching.
`timescale 1ns/1ps
module sps_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic vcc_above_trip,
  input wire logic vcc_above_uvlo,
  input wire logic vcc_above_startup,
  input wire logic latch_above_en,
  input wire logic latch_below_prot,
  input wire logic pfc_ss_charged,
  input wire logic fb_ss_charged,
  input wire logic pfc_sense_above_lim,
  input wire logic flyback_control_input_timeout,
  input wire logic power_factor_output_sense_ovp,
  input wire logic mains_below_stop,
  input wire logic mains_above_start,
  input wire logic overtemp,
  input wire logic aux_demag,
  input wire logic aux_valley,
  input wire logic pfc_ton_done,
  output logic hv_charge_on,
  output logic hv_charge_high,
  output logic internal_enable,
  output logic latch_src_on,
  output logic ss_charge_on,
  output logic pfc_ss_src_on,
  output logic pfc_ss_src_limit,
  output logic pfc_enable,
  output logic fb_enable,
  output logic fb_drive_enable,
  output logic power_factor_gate_pulse,
  output logic zero_current_indication,
  output logic error_flag,
  output logic protect_latched,
  output logic otp_latched
);
  import sps_pkg::*;

  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  sps_cmp_t cmp_raw;
  sps_cmp_t cmp;
  logic [CMP_W-1:0] cmp_vec;

  assign cmp_raw = '{vcc_above_trip, vcc_above_uvlo, vcc_above_startup, latch_above_en,
                     latch_below_prot, pfc_ss_charged, fb_ss_charged, pfc_sense_above_lim,
                     flyback_control_input_timeout, power_factor_output_sense_ovp, mains_below_stop, mains_above_start,
                     overtemp, aux_demag, aux_valley, pfc_ton_done};

  sps_sync #(.W(CMP_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(cmp_raw),
    .sync_out(cmp_vec)
  );
  assign cmp = cmp_vec;

  // ----------------------------------------------------------------
  // fallback timers
  // ----------------------------------------------------------------
  sps_tmr_if zcs_if();
  sps_tmr_if valley_if();

  sps_timer #(.W(CNT_W), .DELAY(ZCS_CYC)) u_zcs_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .tif(zcs_if.timer)
  );
  sps_timer #(.W(CNT_W), .DELAY(VALLEY_CYC)) u_valley_tmr (
    .clk(clk),
    .rst_b(rst_b),
    .tif(valley_if.timer)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sps_seq_t seq;
    sps_phase_t ph;
    logic pfc_en;
    logic fb_en;
    logic latch_seen;
    logic prot_latched;
    logic otp_latched;
    logic error;
    logic mains_ok;
    logic reset_armed;
    logic pfc_started;
    logic gate;
    logic zci;
    logic demag_d;
    logic valley_d;
    logic [CNT_W-1:0] period;
  } sps_top_st_t;

  localparam sps_top_st_t ST_RESET = '{seq: SEQ_CHARGE, ph: PH_IDLE, period: '0, default: 1'b0};

  sps_top_st_t st_r;
  sps_top_st_t st_nxt;

  logic pfc_allowed;
  logic period_ok;
  logic demag_evt;
  logic valley_evt;
  logic stroke_end;
  logic demag_rise;
  logic valley_rise;

  // ----------------------------------------------------------------
  // stroke qualifiers
  // ----------------------------------------------------------------
  // overvoltage and mains brownout only pause switching, nothing latches
  assign pfc_allowed = (st_r.seq == SEQ_START || st_r.seq == SEQ_RUN) && st_r.pfc_en &&
                       st_r.latch_seen && !cmp.power_factor_output_sense_ovp && st_r.mains_ok;
  assign period_ok = st_r.period >= CNT_W'(PFC_MIN_PERIOD_CYC);
  assign demag_rise = cmp.aux_demag && !st_r.demag_d;
  assign valley_rise = cmp.aux_valley && !st_r.valley_d;
  assign stroke_end = (st_r.ph == PH_ON) && (cmp.pfc_ton_done || !pfc_allowed);
  assign demag_evt = (st_r.ph == PH_DEMAG) && (demag_rise || zcs_if.expired);
  assign valley_evt = (st_r.ph == PH_VALLEY) && (valley_rise || valley_if.expired);

  // timers restart at gate end and at demagnetization
  assign zcs_if.restart = stroke_end;
  assign valley_if.restart = demag_evt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.zci = 1'b0;
    st_nxt.demag_d = cmp.aux_demag;
    st_nxt.valley_d = cmp.aux_valley;
    if (st_r.period != '1) begin
      st_nxt.period = st_r.period + CNT_W'(1);
    end

    // mains hysteresis for the power-factor stage
    if (cmp.mains_below_stop) begin
      st_nxt.mains_ok = 1'b0;
    end else if (cmp.mains_above_start) begin
      st_nxt.mains_ok = 1'b1;
    end

    // fast reset: dip below the low level, then rise to the high one
    if (cmp.mains_below_stop) begin
      st_nxt.reset_armed = 1'b1;
    end else if (st_r.reset_armed && cmp.mains_above_start) begin
      st_nxt.reset_armed = 1'b0;
      if (st_r.seq == SEQ_LATCHED) begin
        st_nxt.prot_latched = 1'b0;
        st_nxt.otp_latched = 1'b0;
        st_nxt.error = 1'b0;
        st_nxt.seq = SEQ_CHARGE;
      end
    end

    // sequencer
    case (st_r.seq)
      SEQ_CHARGE: begin
        if (st_r.prot_latched || st_r.otp_latched) begin
          st_nxt.seq = SEQ_LATCHED;
        end else if (cmp.vcc_above_startup) begin
          st_nxt.seq = SEQ_START;
          st_nxt.latch_seen = 1'b0;
        end
      end
      SEQ_START: begin
        // latch input is taken unfiltered, only synchronised
        if (cmp.latch_above_en) begin
          st_nxt.latch_seen = 1'b1;
        end
        if (st_r.latch_seen && cmp.pfc_ss_charged) begin
          st_nxt.pfc_en = 1'b1;
        end
        if (st_r.latch_seen && cmp.fb_ss_charged) begin
          st_nxt.fb_en = 1'b1;
          st_nxt.seq = SEQ_RUN;
        end
        if (!cmp.vcc_above_uvlo) begin
          st_nxt.seq = SEQ_CHARGE;
        end
      end
      SEQ_RUN: begin
        if (cmp.flyback_control_input_timeout) begin
          st_nxt.error = 1'b1;
          st_nxt.seq = SEQ_CHARGE;
        end else if (!cmp.vcc_above_uvlo) begin
          st_nxt.seq = SEQ_CHARGE;
        end
      end
      SEQ_LATCHED: begin
        // recharges unless overtemperature is latched, never restarts until a latch is cleared
      end
      default: begin
        st_nxt.seq = SEQ_CHARGE;
      end
    endcase

    // protections win over a simultaneous fast reset
    if (st_r.seq == SEQ_START || st_r.seq == SEQ_RUN) begin
      if (st_r.latch_seen && cmp.latch_below_prot) begin
        st_nxt.prot_latched = 1'b1;
        st_nxt.seq = SEQ_LATCHED;
      end
      if (cmp.overtemp) begin
        st_nxt.otp_latched = 1'b1;
        st_nxt.seq = SEQ_LATCHED;
      end
    end

    // leaving the active states stops both converters
    if (st_nxt.seq != SEQ_START && st_nxt.seq != SEQ_RUN) begin
      st_nxt.pfc_en = 1'b0;
      st_nxt.fb_en = 1'b0;
      st_nxt.pfc_started = 1'b0;
    end

    // power-factor stroke sequence
    case (st_r.ph)
      PH_IDLE: begin
        if (pfc_allowed) begin
          st_nxt.gate = 1'b1;
          st_nxt.pfc_started = 1'b1;
          st_nxt.period = '0;
          st_nxt.ph = PH_ON;
        end
      end
      PH_ON: begin
        if (stroke_end) begin
          st_nxt.gate = 1'b0;
          st_nxt.ph = PH_DEMAG;
        end
      end
      PH_DEMAG: begin
        if (demag_evt) begin
          st_nxt.zci = 1'b1;
          st_nxt.ph = PH_VALLEY;
        end
      end
      PH_VALLEY: begin
        // a valley inside the shortest period is skipped: the next one is used
        if (valley_evt && period_ok) begin
          st_nxt.ph = PH_IDLE;
          if (pfc_allowed) begin
            st_nxt.gate = 1'b1;
            st_nxt.period = '0;
            st_nxt.ph = PH_ON;
          end
        end
      end
      default: begin
        st_nxt.ph = PH_IDLE;
      end
    endcase
    if (st_nxt.seq != SEQ_START && st_nxt.seq != SEQ_RUN) begin
      st_nxt.gate = 1'b0;
    end
  end

  // power-on reset is the only path that clears everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // overtemperature keeps the startup pin from recharging the supply
  assign hv_charge_on = (st_r.seq == SEQ_CHARGE || st_r.seq == SEQ_LATCHED) &&
                        !st_r.otp_latched;
  assign hv_charge_high = hv_charge_on && cmp.vcc_above_trip && !cmp.vcc_above_uvlo;
  assign internal_enable = (st_r.seq == SEQ_START || st_r.seq == SEQ_RUN);
  assign latch_src_on = internal_enable;
  assign ss_charge_on = internal_enable;
  assign pfc_ss_src_on = internal_enable && !st_r.pfc_started;
  assign pfc_ss_src_limit = pfc_ss_src_on && cmp.pfc_sense_above_lim;
  assign pfc_enable = st_r.pfc_en;
  assign fb_enable = st_r.fb_en;
  assign fb_drive_enable = (st_r.seq == SEQ_RUN) && st_r.fb_en;
  assign power_factor_gate_pulse = st_r.gate;
  assign zero_current_indication = st_r.zci;
  assign error_flag = st_r.error;
  assign protect_latched = st_r.prot_latched;
  assign otp_latched = st_r.otp_latched;
endmodule

/* inc/sps_pkg.sv */
// shared constants and types of the start-up and protection sequencer
package sps_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_ZCS_NS = 50000;             // zero-current fallback after gate end
  localparam int T_VALLEY_NS = 4000;           // valley fallback after demagnetization
  localparam int T_PFC_MIN_PERIOD_NS = 4000;   // shortest stroke period (frequency limit)
  localparam int ZCS_CYC = T_ZCS_NS / CLK_PERIOD_NS;
  localparam int VALLEY_CYC = T_VALLEY_NS / CLK_PERIOD_NS;
  localparam int PFC_MIN_PERIOD_CYC = (T_PFC_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;

  // ----------------------------------------------------------------
  // comparator bundle, one bit per analogue comparator
  // ----------------------------------------------------------------
  typedef struct packed {
    logic vcc_above_trip;
    logic vcc_above_uvlo;
    logic vcc_above_startup;
    logic latch_above_en;
    logic latch_below_prot;
    logic pfc_ss_charged;
    logic fb_ss_charged;
    logic pfc_sense_above_lim;
    logic flyback_control_input_timeout;
    logic power_factor_output_sense_ovp;
    logic mains_below_stop;
    logic mains_above_start;
    logic overtemp;
    logic aux_demag;
    logic aux_valley;
    logic pfc_ton_done;
  } sps_cmp_t;

  localparam int CMP_W = $bits(sps_cmp_t);
  localparam logic [CMP_W-1:0] CMP_RESET = '0;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEQ_CHARGE  = 4'h1,
    SEQ_START   = 4'h2,
    SEQ_RUN     = 4'h4,
    SEQ_LATCHED = 4'h8
  } sps_seq_t;

  typedef enum logic [3:0] {
    PH_IDLE   = 4'h1,
    PH_ON     = 4'h2,
    PH_DEMAG  = 4'h4,
    PH_VALLEY = 4'h8
  } sps_phase_t;

endpackage

/* inc/sps_tmr_if.sv */
// carrier between the sequencer and one fallback delay timer
`timescale 1ns/1ps
interface sps_tmr_if;
  logic restart;
  logic expired;
  modport timer (input restart, output expired);
  modport user (output restart, input expired);
endinterface

/* rtl/sps_sync.sv */
// two-stage synchroniser for a vector of comparator results
`timescale 1ns/1ps
module sps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sps_sync_st_t;

  sps_sync_st_t st_r;
  sps_sync_st_t st_nxt;

  // first stage feeds only the second one
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;
endmodule

/* rtl/sps_timer.sv */
// one-shot delay timer, restartable, one-cycle expiry pulse
`timescale 1ns/1ps
module sps_timer #(
  parameter int W = 10,
  parameter int DELAY = 500
) (
  input wire logic clk,
  input wire logic rst_b,
  sps_tmr_if.timer tif
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic running;
    logic expired;
  } sps_tmr_st_t;

  sps_tmr_st_t st_r;
  sps_tmr_st_t st_nxt;

  // a restart reloads the count even while running, so the delay
  // is always measured from the latest event
  always_comb begin
    st_nxt = st_r;
    st_nxt.expired = 1'b0;
    if (tif.restart) begin
      st_nxt.cnt = W'(DELAY - 1);
      st_nxt.running = 1'b1;
    end else if (st_r.running) begin
      if (st_r.cnt == '0) begin
        st_nxt.running = 1'b0;
        st_nxt.expired = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tif.expired = st_r.expired;
endmodule

/* tb/sps_top_properties.sv */
// concurrent checks on the sequencer top-level ports
`timescale 1ns/1ps
module sps_top_properties
  import sps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic vcc_above_trip,
  input wire logic vcc_above_uvlo,
  input wire logic pfc_ss_charged,
  input wire logic latch_below_prot,
  input wire logic overtemp,
  input wire logic pfc_ton_done,
  input wire logic hv_charge_on,
  input wire logic hv_charge_high,
  input wire logic internal_enable,
  input wire logic latch_src_on,
  input wire logic ss_charge_on,
  input wire logic pfc_ss_src_on,
  input wire logic pfc_enable,
  input wire logic fb_enable,
  input wire logic fb_drive_enable,
  input wire logic power_factor_gate_pulse,
  input wire logic zero_current_indication,
  input wire logic protect_latched,
  input wire logic otp_latched
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // inputs pass two sync flops, so state reacts on the third edge
  localparam int ZCS_LIM = ZCS_CYC + 5;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_charge_level;
    hv_charge_high |-> $past(vcc_above_trip, 2) && !$past(vcc_above_uvlo, 2);
  endproperty
  a_charge_level: assert property (p_charge_level) else $error("high charge current out of band");
  property p_start_on;
    internal_enable |-> !hv_charge_on && latch_src_on && ss_charge_on;
  endproperty
  a_start_on: assert property (p_start_on) else $error("active state with charge current on");
  property p_pfc_en;
    $rose(pfc_enable) |-> $past(pfc_ss_charged, 3);
  endproperty
  a_pfc_en: assert property (p_pfc_en) else $error("pfc enabled before soft-start charged");
  property p_fb_drive;
    fb_drive_enable |-> fb_enable && internal_enable;
  endproperty
  a_fb_drive: assert property (p_fb_drive) else $error("flyback driven while not enabled");
  property p_uvlo;
    !vcc_above_uvlo [*4] |-> !fb_drive_enable && !power_factor_gate_pulse;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("drivers active under lockout");
  property p_latch_prot;
    (fb_drive_enable && latch_below_prot) ##1 latch_below_prot [*2]
      |=> protect_latched && !fb_drive_enable && !power_factor_gate_pulse;
  endproperty
  a_latch_prot: assert property (p_latch_prot) else $error("low latch input not latched");
  property p_otp;
    (internal_enable && overtemp) ##1 overtemp [*2] |=> otp_latched && !hv_charge_on && !power_factor_gate_pulse;
  endproperty
  a_otp: assert property (p_otp) else $error("overtemperature not handled");
  property p_ss_src;
    power_factor_gate_pulse && $past(power_factor_gate_pulse) |-> !pfc_ss_src_on;
  endproperty
  a_ss_src: assert property (p_ss_src) else $error("soft-start source on while switching");
  property p_zcs;
    $fell(power_factor_gate_pulse) && $past(pfc_ton_done) && pfc_enable |-> ##[0:ZCS_LIM] zero_current_indication;
  endproperty
  a_zcs: assert property (p_zcs) else $error("no zero-current indication after stroke");
  // main scenarios reached
  c_gate: cover property ($rose(power_factor_gate_pulse));
  c_prot: cover property ($rose(protect_latched));
  c_otp: cover property ($rose(otp_latched));
endmodule

bind sps_top sps_top_properties u_props (.clk(clk), .rst_b(rst_b), .vcc_above_trip(vcc_above_trip),
  .vcc_above_uvlo(vcc_above_uvlo), .pfc_ss_charged(pfc_ss_charged), .latch_below_prot(latch_below_prot),
  .overtemp(overtemp), .pfc_ton_done(pfc_ton_done), .hv_charge_on(hv_charge_on), .hv_charge_high(hv_charge_high),
  .internal_enable(internal_enable), .latch_src_on(latch_src_on), .ss_charge_on(ss_charge_on),
  .pfc_ss_src_on(pfc_ss_src_on), .pfc_enable(pfc_enable), .fb_enable(fb_enable),
  .fb_drive_enable(fb_drive_enable), .power_factor_gate_pulse(power_factor_gate_pulse),
  .zero_current_indication(zero_current_indication), .protect_latched(protect_latched), .otp_latched(otp_latched));

/* tb/sps_stage_model.sv */
// model of the pfc power stage: on-time comparator and aux winding
`timescale 1ns/1ps
module sps_stage_model (
  input wire logic clk,
  input wire logic gate,
  input wire logic demag_en,
  input wire logic valley_en,
  input wire logic fast,
  output logic ton_done,
  output logic demag,
  output logic valley
);
  logic gate_q = 1'b0;
  int cnt = 0;
  initial begin
    ton_done = 1'b0;
    demag = 1'b0;
    valley = 1'b0;
  end
  // cycles counted from each gate edge; valley rings every 8 cycles after demag,
  // so a stroke held off by the frequency limit still finds a later valley
  // the count is trusted only once gate_q agrees with gate: on the edge that sees
  // a gate change it still holds the length of the previous phase
  always @(posedge clk) begin
    gate_q <= gate;
    cnt <= (gate != gate_q) ? 0 : cnt + 1;
    ton_done <= gate && gate_q && cnt >= (fast ? 2 : 10);
    demag <= !gate && !gate_q && demag_en && cnt >= (fast ? 4 : 30);
    valley <= !gate && valley_en && demag && cnt[2:0] == 3'h7;
  end
endmodule

/* tb/tb.sv */
// self-checking bench for the start-up and protection sequencer
`timescale 1ns/1ps
module tb;
  import sps_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic trip = 0, uvlo = 0, sup = 0, len = 0, lp = 0, pss = 0, fss = 0, lim = 0, fbto = 0;
  logic ovp = 0, mstop = 0, mstart = 0, otemp = 0, dm_en = 1, vl_en = 1, fast = 0;
  logic dm, vl, td, hv_on, hv_hi, ien, lsrc, ssc, psrc, plim, pen, fen, fdrv, gate, zci, err, plat, olat;
  int failures = 0;
  int samples_checked = 0;
  int n, m;

  sps_top uut (.clk(clk), .rst_b(rst_b), .vcc_above_trip(trip), .vcc_above_uvlo(uvlo), .vcc_above_startup(sup),
    .latch_above_en(len), .latch_below_prot(lp), .pfc_ss_charged(pss), .fb_ss_charged(fss),
    .pfc_sense_above_lim(lim), .flyback_control_input_timeout(fbto), .power_factor_output_sense_ovp(ovp), .mains_below_stop(mstop),
    .mains_above_start(mstart), .overtemp(otemp), .aux_demag(dm), .aux_valley(vl), .pfc_ton_done(td),
    .hv_charge_on(hv_on), .hv_charge_high(hv_hi), .internal_enable(ien), .latch_src_on(lsrc),
    .ss_charge_on(ssc), .pfc_ss_src_on(psrc), .pfc_ss_src_limit(plim), .pfc_enable(pen), .fb_enable(fen),
    .fb_drive_enable(fdrv), .power_factor_gate_pulse(gate), .zero_current_indication(zci), .error_flag(err),
    .protect_latched(plat), .otp_latched(olat));
  sps_stage_model stage (.clk(clk), .gate(gate), .demag_en(dm_en), .valley_en(vl_en), .fast(fast),
    .ton_done(td), .demag(dm), .valley(vl));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 10 MHz clock
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // outputs are read at the falling edge, clear of the launching edge
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // counts cycles until gate (sel 0) or zci (sel 1) shows lvl, bounded by lim
  task automatic wt(input logic sel, input logic lvl, input int lim);
    n = 0;
    while ((sel ? zci : gate) !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // a hung wait would otherwise stall the run; 50000 cycles is far beyond the tests
  initial begin
    #5000000;
    failures++;
    give_verdict();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_charge();
    chk({hv_on, hv_hi, ien, gate, plat, olat}, 6'h20);
    @(posedge clk);
    trip <= 1'b1;
    cyc(4);
    chk({hv_on, hv_hi}, 2'b11);
    @(posedge clk);
    uvlo <= 1'b1;
    cyc(4);
    chk({hv_on, hv_hi}, 2'b10);
    $display("test charge done");
  endtask
  task automatic t_start();
    @(posedge clk);
    sup <= 1'b1;
    lim <= 1'b1;
    cyc(5);
    chk({hv_on, ien, lsrc, ssc, psrc, plim}, 6'h1F);
    @(posedge clk);
    pss <= 1'b1;
    cyc(10);
    chk(pen, 1'b0);
    @(posedge clk);
    len <= 1'b1;
    fss <= 1'b1;
    cyc(6);
    chk({pen, fen, fdrv, gate}, 4'hE);
    @(posedge clk);
    mstart <= 1'b1;
    wt(0, 1, 100);
    chk(n < 10, 1'b1);
    cyc(3);
    chk(psrc, 1'b0);
    $display("test start done");
  endtask
  task automatic t_stroke();
    wt(0, 0, 100);
    chk(n > 8 && n < 17, 1'b1);
    wt(1, 1, 100);
    chk(n < 40, 1'b1);
    wt(0, 1, 100);
    chk(n < 20, 1'b1);
    @(posedge clk);
    dm_en <= 1'b0;
    wt(0, 0, 100);
    wt(1, 1, 600);
    chk(n >= ZCS_CYC - 4 && n <= ZCS_CYC + 2, 1'b1);
    wt(0, 1, 100);
    chk(n >= VALLEY_CYC - 3 && n <= VALLEY_CYC + 3, 1'b1);
    @(posedge clk);
    dm_en <= 1'b1;
    vl_en <= 1'b0;
    wt(0, 0, 100);
    wt(1, 1, 100);
    wt(0, 1, 100);
    chk(n >= VALLEY_CYC - 3 && n <= VALLEY_CYC + 3, 1'b1);
    @(posedge clk);
    vl_en <= 1'b1;
    fast <= 1'b1;
    wt(0, 0, 100);
    wt(0, 1, 100);
    wt(0, 0, 100);
    m = n;
    wt(0, 1, 100);
    chk(m + n >= PFC_MIN_PERIOD_CYC && m + n <= PFC_MIN_PERIOD_CYC + 13, 1'b1);
    @(posedge clk);
    fast <= 1'b0;
    $display("test stroke done");
  endtask
  task automatic t_halt();
    @(posedge clk);
    ovp <= 1'b1;
    wt(0, 0, 100);
    cyc(3);
    wt(0, 1, 600);
    chk(n, 600);
    @(posedge clk);
    ovp <= 1'b0;
    wt(0, 1, 700);
    chk(n < 700, 1'b1);
    @(posedge clk);
    mstop <= 1'b1;
    mstart <= 1'b0;
    wt(0, 0, 100);
    cyc(3);
    @(posedge clk);
    mstop <= 1'b0;
    wt(0, 1, 600);
    chk(n, 600);
    @(posedge clk);
    mstart <= 1'b1;
    wt(0, 1, 700);
    chk(n < 700, 1'b1);
    $display("test halt done");
  endtask
  task automatic t_uvlo();
    @(posedge clk);
    uvlo <= 1'b0;
    sup <= 1'b0;
    cyc(5);
    chk({fdrv, gate, ien, hv_on}, 4'h1);
    @(posedge clk);
    len <= 1'b0;
    uvlo <= 1'b1;
    sup <= 1'b1;
    cyc(5);
    chk({ien, pen}, 2'b10);
    @(posedge clk);
    uvlo <= 1'b0;
    sup <= 1'b0;
    cyc(5);
    chk({ien, hv_on}, 2'b01);
    @(posedge clk);
    len <= 1'b1;
    uvlo <= 1'b1;
    sup <= 1'b1;
    cyc(8);
    chk(fdrv, 1'b1);
    $display("test uvlo done");
  endtask
  task automatic t_faults();
    @(posedge clk);
    fbto <= 1'b1;
    sup <= 1'b0;
    cyc(5);
    chk({err, ien, hv_on}, 3'b101);
    @(posedge clk);
    fbto <= 1'b0;
    sup <= 1'b1;
    cyc(8);
    chk({err, ien, fdrv}, 3'b111);
    @(posedge clk);
    lp <= 1'b1;
    cyc(5);
    chk({plat, ien, fdrv, gate}, 4'h8);
    @(posedge clk);
    lp <= 1'b0;
    sup <= 1'b0;
    cyc(5);
    chk(hv_on, 1'b1);
    @(posedge clk);
    sup <= 1'b1;
    cyc(10);
    chk(ien, 1'b0);
    @(posedge clk);
    mstop <= 1'b1;
    mstart <= 1'b0;
    cyc(5);
    chk(plat, 1'b1);
    @(posedge clk);
    mstop <= 1'b0;
    mstart <= 1'b1;
    cyc(5);
    chk({plat, err}, 2'b00);
    cyc(5);
    chk(ien, 1'b1);
    $display("test faults done");
  endtask
  task automatic t_otp();
    @(posedge clk);
    otemp <= 1'b1;
    cyc(5);
    chk({olat, gate, fdrv}, 3'b100);
    @(posedge clk);
    sup <= 1'b0;
    otemp <= 1'b0;
    cyc(5);
    chk({olat, hv_on}, 2'b10);
    @(posedge clk);
    rst_b <= 1'b0;
    cyc(2);
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(5);
    chk({olat, hv_on}, 2'b01);
    $display("test otp done");
  endtask

  // main sequence: reset held six cycles, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    t_charge();
    t_start();
    t_stroke();
    t_halt();
    t_uvlo();
    t_faults();
    t_otp();
    give_verdict();
  end
endmodule
